// [core/spi_front_end.sv]
// Serial bus front end: pin sampling, shifting, pause, protect freeze
//
// Function
// R01 - Array of 65536 bytes, reached only through the serial bus.
// R02 - Optional identification page of 128 bytes, lockable to read-only.
// R03 - Device answers bus traffic only while chip select is low.
// R04 - Output bits change on falling serial clock edges.
// R05 - Input bits are captured on rising serial clock edges.
// R06 - Deselected device floats its data output.
// R07 - Deselect means standby unless a write runs; select means active.
// R08 - After power-up, a chip select falling edge is needed first.
// R09 - Pause input suspends transfer, which later resumes where it stopped.
// R10 - While paused, output floats; clock and data input are ignored.
// R11 - Pause only while selected; master keeps select low during pause.
// R12 - Write-protect low freezes the protect field.
// R13 - Master holds write-protect steady through every write instruction.
// R14 - Bytes travel most significant bit first.
// R15 - First input bit taken on first rising edge after select.
// R16 - Output MSB first, from first falling edge after instruction.
// R17 - Works in clock idle low and idle high modes alike.
// R18 - Pause starts and ends on pause input edges while clock is low.
// R19 - Deselect during pause resets sequencing, keeping latch and busy flags.
// R20 - Received bytes with position go to decoder; decoder supplies output bytes.
`timescale 1ns/1ps
module spi_front_end (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Bus pins
    input wire logic sclk,
    input wire logic sdi,
    input wire logic cs_n,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic sdo,
    output logic sdo_oe_n,
    // Received bytes towards the decoder
    output spi_front_pkg::rx_byte_t rx_byte,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_overrun,
    // Output bytes from the decoder
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    // Frame status
    output logic frame_active,
    output logic frame_abort,
    output logic standby,
    input wire logic write_in_progress_flag,
    // Protect field and write permission
    input wire logic [1:0] prot_wr_value,
    input wire logic prot_wr_valid,
    output logic [1:0] protect_field,
    output logic prot_wr_refused,
    input wire logic id_lock_req,
    output logic id_locked,
    input wire spi_front_pkg::chk_req_t chk_req,
    input wire logic chk_valid,
    output logic chk_done,
    output logic chk_permit
);

    // Region test of the permission check; the top code covers the whole array
    function automatic logic in_protected(input logic [1:0] field, input logic [15:0] addr);
        return (field == spi_front_pkg::PROT_NONE) ? 1'b0
            : (field == spi_front_pkg::PROT_QUARTER) ? (addr >= spi_front_pkg::QUARTER_FLOOR)
            : (field == spi_front_pkg::PROT_HALF) ? (addr >= spi_front_pkg::HALF_FLOOR)
            : 1'b1;
    endfunction

    logic [spi_front_pkg::PIN_W-1:0] s1, s2, s3, pin_q, pin_prev;
    logic frame, paused, out_active, tx_full;
    logic [2:0] bit_cnt;
    logic [7:0] byte_index, rx_shift, tx_shift, tx_hold;
    logic head_valid, tail_valid;
    spi_front_pkg::rx_byte_t tail;

    // Three-stage sampling; a level counts once stages two and three agree
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1 <= spi_front_pkg::SYNC_RESET;
            s2 <= spi_front_pkg::SYNC_RESET;
            s3 <= spi_front_pkg::SYNC_RESET;
            pin_q <= spi_front_pkg::SYNC_RESET;
            pin_prev <= spi_front_pkg::SYNC_RESET;
        end
        else
        begin
            s1 <= {wp_n, hold_n, cs_n, sdi, sclk};
            s2 <= s1;
            s3 <= s2;
            pin_q <= (s2 & s3) | (pin_q & (s2 ^ s3));
            pin_prev <= pin_q;
        end
    end

    // Clean levels and edges; data and clock share the same delay
    wire sclk_q = pin_q[spi_front_pkg::PIN_SCLK];
    wire sdi_q = pin_q[spi_front_pkg::PIN_SDI];
    wire cs_q = pin_q[spi_front_pkg::PIN_CS_N];
    wire hold_q = pin_q[spi_front_pkg::PIN_HOLD_N];
    wire wp_q = pin_q[spi_front_pkg::PIN_WP_N];
    wire sclk_rise = sclk_q & ~pin_prev[spi_front_pkg::PIN_SCLK]; // R05 R17
    wire sclk_fall = ~sclk_q & pin_prev[spi_front_pkg::PIN_SCLK]; // R04 R17
    // Reset drives the sampled select low, so only a real high can make a fall
    wire cs_fall = ~cs_q & pin_prev[spi_front_pkg::PIN_CS_N]; // R08
    wire cs_rise = cs_q & ~pin_prev[spi_front_pkg::PIN_CS_N];

    // Pause entry only with the clock low and the device selected; exit with the clock low, or at once on deselect
    wire pause_enter = frame & ~paused & ~hold_q & ~sclk_q; // R18 R11
    wire pause_leave = paused & hold_q & ~sclk_q; // R18
    wire next_paused = frame & ~cs_q & (pause_enter | (paused & ~pause_leave)); // R09
    // Clock and data are dropped while paused or deselected
    wire take_rise = frame & ~paused & sclk_rise; // R03 R10
    wire take_fall = frame & ~paused & sclk_fall; // R03 R10
    wire byte_done = take_rise & (bit_cnt == spi_front_pkg::BIT_CNT_LAST);
    wire [7:0] next_rx = {rx_shift[6:0], sdi_q}; // R14

    // Output byte loaded only at a byte boundary once an instruction is in
    wire boundary = take_fall & (bit_cnt == spi_front_pkg::BIT_CNT_RESET)
                    & (byte_index != spi_front_pkg::BYTE_INDEX_RESET); // R16
    wire tx_load = boundary & tx_full;
    wire tx_take = tx_valid & tx_ready;

    // Frame, pause and bit position
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            frame <= 1'b0;
            paused <= 1'b0;
            bit_cnt <= spi_front_pkg::BIT_CNT_RESET;
            byte_index <= spi_front_pkg::BYTE_INDEX_RESET;
            rx_shift <= spi_front_pkg::BYTE_RESET;
        end
        else if (cs_fall)
        begin
            frame <= 1'b1; // R07 R08
            paused <= 1'b0;
            bit_cnt <= spi_front_pkg::BIT_CNT_RESET; // R15
            byte_index <= spi_front_pkg::BYTE_INDEX_RESET;
        end
        else
        begin
            frame <= frame & ~cs_q; // R03
            paused <= next_paused;
            if (take_rise)
            begin
                bit_cnt <= bit_cnt + 3'h1;
                rx_shift <= next_rx; // R05
            end
            if (byte_done && byte_index != spi_front_pkg::BYTE_INDEX_MAX)
            begin
                byte_index <= byte_index + 8'h01;
            end
        end
    end

    // Output shifter and the holding byte from the decoder
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_shift <= spi_front_pkg::BYTE_RESET;
            tx_hold <= spi_front_pkg::BYTE_RESET;
            tx_full <= 1'b0;
            tx_ready <= 1'b1;
            out_active <= 1'b0;
        end
        else
        begin
            if (tx_take)
            begin
                tx_hold <= tx_data; // R20
            end
            // New byte wins over the load; frame end drops a stale byte for the next frame
            tx_full <= frame & (tx_take | (tx_full & ~tx_load)); // R03
            tx_ready <= frame & ~cs_q & ~(tx_take | (tx_full & ~tx_load)); // R20
            if (!frame)
            begin
                out_active <= 1'b0;
            end
            else if (boundary)
            begin
                out_active <= tx_full; // R16
                tx_shift <= tx_hold;
            end
            else if (take_fall)
            begin
                tx_shift <= {tx_shift[6:0], 1'b0}; // R04 R14
            end
        end
    end

    // Pin drivers registered so they never glitch
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sdo <= 1'b0;
            sdo_oe_n <= 1'b1;
        end
        else
        begin
            sdo <= tx_shift[7];
            sdo_oe_n <= ~(frame & ~paused & out_active); // R06 R10
        end
    end

    // Two-entry buffer: decoder stalls cost nothing until both are full
    wire pop = rx_valid & rx_ready;
    wire push = byte_done & ~tail_valid; // R20
    wire fill_head = push & (~head_valid | (pop & ~tail_valid));
    wire [7:0] push_index = byte_index;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_byte <= '0;
            tail <= '0;
            head_valid <= 1'b0;
            tail_valid <= 1'b0;
            rx_valid <= 1'b0;
            rx_overrun <= 1'b0;
        end
        else
        begin
            if (pop && tail_valid)
            begin
                rx_byte <= tail;
            end
            else if (fill_head)
            begin
                rx_byte <= '{data: next_rx, index: push_index};
            end
            if (push && !fill_head)
            begin
                tail <= '{data: next_rx, index: push_index};
            end
            head_valid <= (head_valid & ~pop) | tail_valid | push;
            tail_valid <= (tail_valid & ~pop) | (push & ~fill_head);
            rx_valid <= (head_valid & ~pop) | tail_valid | push;
            // Serial clock cannot be stalled, so a full buffer drops the byte
            rx_overrun <= (byte_done & tail_valid) | (rx_overrun & ~cs_fall); // R20
        end
    end

    // Frame status towards the decoder and power control
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            frame_active <= 1'b0;
            frame_abort <= 1'b0;
            standby <= 1'b1;
        end
        else
        begin
            frame_active <= frame;
            // Latch and busy flag live in the decoder and survive this
            frame_abort <= cs_rise & paused; // R19
            standby <= ~frame & ~write_in_progress_flag; // R07
        end
    end

    // Protect field freeze and write permission answers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            protect_field <= spi_front_pkg::PROTECT_INIT;
            prot_wr_refused <= 1'b0;
            id_locked <= 1'b0;
            chk_done <= 1'b0;
            chk_permit <= 1'b0;
        end
        else
        begin
            if (prot_wr_valid && wp_q)
            begin
                protect_field <= prot_wr_value; // R12
            end
            prot_wr_refused <= prot_wr_valid & ~wp_q; // R12
            id_locked <= id_locked | id_lock_req; // R02
            chk_done <= chk_valid;
            chk_permit <= chk_valid & (chk_req.id_page
                ? (~id_locked & (chk_req.addr < 16'(spi_front_pkg::ID_PAGE_BYTES))) // R02
                : ~in_protected(protect_field, chk_req.addr)); // R01 R12
        end
    end

    // Checks beside the logic they guard
    a_float_deselect: assert property (@(posedge clk) disable iff (!rstn) !frame |=> sdo_oe_n) // R06
        else $error("data output driven while deselected");
    a_float_paused: assert property (@(posedge clk) disable iff (!rstn) paused |=> sdo_oe_n) // R10
        else $error("data output driven while paused");
    a_byte_needs_select: assert property (@(posedge clk) disable iff (!rstn)
        byte_done |-> frame && !paused && !cs_q) // R03
        else $error("byte taken outside an active frame");
    a_first_bit_start: assert property (@(posedge clk) disable iff (!rstn)
        cs_fall |=> bit_cnt == 3'h0 && frame) // R15
        else $error("bit position not cleared at select");
    a_msb_shift_in: assert property (@(posedge clk) disable iff (!rstn)
        take_rise |=> rx_shift[0] == $past(sdi_q) && rx_shift[7:1] == $past(rx_shift[6:0])) // R14
        else $error("input bit not shifted in at the low end");
    a_out_from_fall: assert property (@(posedge clk) disable iff (!rstn)
        $rose(out_active) |-> $past(sclk_fall) && $past(byte_index) != 8'h00) // R16
        else $error("output started without a falling edge after instruction");
    a_hold_entry: assert property (@(posedge clk) disable iff (!rstn)
        $rose(paused) |-> $past(!sclk_q && !hold_q && frame)) // R18
        else $error("pause entered with clock high or deselected");
    a_hold_keeps_pos: assert property (@(posedge clk) disable iff (!rstn)
        paused ##1 paused |-> $stable(bit_cnt) && $stable(rx_shift)) // R09
        else $error("bit position moved during pause");
    a_protect_frozen: assert property (@(posedge clk) disable iff (!rstn)
        !wp_q |=> protect_field == $past(protect_field)) // R12
        else $error("protect field changed with protection asserted");
    a_standby_select: assert property (@(posedge clk) disable iff (!rstn) frame |=> !standby) // R07
        else $error("standby while selected");
    a_abort_pause: assert property (@(posedge clk) disable iff (!rstn)
        cs_rise && paused |=> frame_abort ##1 !frame_abort) // R19
        else $error("deselect during pause gave no single abort pulse");
    a_buffer_overrun: assert property (@(posedge clk) disable iff (!rstn)
        byte_done && tail_valid |=> rx_overrun && $stable(tail)) // R20
        else $error("byte into full buffer not flagged");
    a_id_locked: assert property (@(posedge clk) disable iff (!rstn)
        chk_valid && chk_req.id_page && id_locked |=> chk_done && !chk_permit) // R02
        else $error("locked identification page granted");

    c_read_out: cover property (@(posedge clk) disable iff (!rstn) $rose(out_active));
    c_pause_resume: cover property (@(posedge clk) disable iff (!rstn) $fell(paused) && frame);
    c_overrun: cover property (@(posedge clk) disable iff (!rstn) $rose(rx_overrun));
    c_prot_refused: cover property (@(posedge clk) disable iff (!rstn) prot_wr_refused);

endmodule // spi_front_end

// [core/spi_front_pkg.sv]
// Constants and carrier types for the serial memory bus front end
package spi_front_pkg;
    // Array geometry
    localparam int MEM_DEPTH = 65536;
    localparam int ADDR_W = 16;
    localparam int ID_PAGE_BYTES = 128;
    // Positions of the pins inside the synchroniser vector
    localparam int PIN_SCLK = 0;
    localparam int PIN_SDI = 1;
    localparam int PIN_CS_N = 2;
    localparam int PIN_HOLD_N = 3;
    localparam int PIN_WP_N = 4;
    localparam int PIN_W = 5;
    // Reset values and counter limits
    localparam logic [4:0] SYNC_RESET = 5'h00;
    localparam logic [2:0] BIT_CNT_RESET = 3'h0;
    localparam logic [2:0] BIT_CNT_LAST = 3'h7;
    localparam logic [7:0] BYTE_INDEX_RESET = 8'h00;
    localparam logic [7:0] BYTE_INDEX_MAX = 8'hFF;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [1:0] PROTECT_INIT = 2'h0;
    // Protect field codes and region floors
    localparam logic [1:0] PROT_NONE = 2'h0;
    localparam logic [1:0] PROT_QUARTER = 2'h1;
    localparam logic [1:0] PROT_HALF = 2'h2;
    localparam logic [15:0] QUARTER_FLOOR = 16'hC000;
    localparam logic [15:0] HALF_FLOOR = 16'h8000;

    // Received byte handed to the decoder
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] index;
    } rx_byte_t;

    // Write permission query from the decoder
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic id_page;
    } chk_req_t;
endpackage

// [tb/spi_master_model.sv]
// Bus master model that drives the serial pins of the front end
`timescale 1ns/1ps
module spi_master_model (
    // Bench clock
    input wire logic clk,
    // Serial pins
    output logic sclk,
    output logic sdi,
    output logic cs_n,
    output logic hold_n,
    output logic wp_n,
    input wire logic miso
);
    logic mode3 = 1'h0;
    logic [7:0] got = 8'h00;

    // Select low from power-up on purpose; write protect stays put in frames
    initial
    begin
        sclk = 1'h0;
        sdi = 1'h0;
        cs_n = 1'h0;
        hold_n = 1'h1;
        wp_n = 1'h1;
    end

    // Half a serial clock period, 80 ns
    task automatic half();
        repeat (8) @(negedge clk);
    endtask

    // Idle clock level first, then a select fall after a real high
    task automatic sel();
        sclk <= mode3;
        half();
        cs_n <= 1'h0;
        half();
    endtask

    // Clock parks at its idle level; released data shows its inverse
    task automatic desel();
        sclk <= mode3;
        half();
        cs_n <= 1'h1;
        sdi <= ~sdi;
        half();
    endtask

    // Data changes with the fall, both sides sample at the rise
    task automatic bit_x(input logic b);
        sclk <= 1'h0;
        sdi <= b;
        half();
        sclk <= 1'h1;
        got = {got[6:0], miso};
        half();
    endtask

    // Whole byte, top bit first
    task automatic byte_x(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
            bit_x(b[i]);
    endtask

    // Pause entered with the clock low, then junk on clock and data
    task automatic pause_on();
        sclk <= 1'h0;
        half();
        hold_n <= 1'h0;
        half();
        repeat (3)
        begin
            sclk <= 1'h1;
            sdi <= ~sdi;
            half();
            sclk <= 1'h0;
            half();
        end
    endtask

    // Pause left with the clock low
    task automatic pause_off();
        hold_n <= 1'h1;
        half();
    endtask
endmodule // spi_master_model

// [tb/tb.sv]
// Self-checking bench for the serial front end
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic sclk, sdi, cs_n, hold_n, wp_n, sdo, sdo_oe_n, miso;
    spi_front_pkg::rx_byte_t rx_byte;
    logic rx_valid, rx_overrun, tx_ready, frame_active, frame_abort, standby;
    logic rx_ready = 1'h0;
    logic [7:0] tx_data = 8'hC3;
    logic tx_valid = 1'h1;
    logic write_in_progress_flag = 1'h0;
    logic [1:0] prot_wr_value = 2'h0;
    logic prot_wr_valid = 1'h0;
    logic id_lock_req = 1'h0;
    logic chk_valid = 1'h0;
    spi_front_pkg::chk_req_t chk_req = 17'h00000;
    logic [1:0] protect_field;
    logic prot_wr_refused, id_locked, chk_done, chk_permit;
    logic [15:0] addrs [6] = '{16'h0000, 16'h7FFF, 16'h8000, 16'hBFFF, 16'hC000, 16'hFFFF};
    int mismatches = 0;
    int checks = 0;
    int aborts = 0;

    // Clock, 10 ns period
    initial
        forever #5 clk = ~clk;

    // Data line floats unless the front end enables it
    assign miso = sdo_oe_n ? 1'hz : sdo;

    // Abort pulses are single cycles, so count them as they pass
    always @(posedge clk)
        if (frame_abort === 1'h1)
            aborts++;

    spi_master_model u_master (.clk(clk), .sclk(sclk), .sdi(sdi), .cs_n(cs_n),
        .hold_n(hold_n), .wp_n(wp_n), .miso(miso));

    spi_front_end u_dut (.clk(clk), .rstn(rstn), .sclk(sclk), .sdi(sdi), .cs_n(cs_n),
        .hold_n(hold_n), .wp_n(wp_n), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_overrun(rx_overrun),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .frame_active(frame_active), .frame_abort(frame_abort), .standby(standby),
        .write_in_progress_flag(write_in_progress_flag), .prot_wr_value(prot_wr_value),
        .prot_wr_valid(prot_wr_valid), .protect_field(protect_field),
        .prot_wr_refused(prot_wr_refused), .id_lock_req(id_lock_req),
        .id_locked(id_locked), .chk_req(chk_req), .chk_valid(chk_valid),
        .chk_done(chk_done), .chk_permit(chk_permit));

    task automatic give_verdict();
        if (mismatches == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Judge the buffer head, then pop it
    task automatic pop(input logic [7:0] d, input logic [7:0] idx);
        `CHK("rx_valid", 1'h1, rx_valid)
        `CHK("rx_data", d, rx_byte.data)
        `CHK("rx_index", idx, rx_byte.index)
        rx_ready <= 1'h1;
        @(negedge clk) rx_ready <= 1'h0;
        @(negedge clk);
    endtask

    // Clocking with select held low since power-up must be ignored
    task automatic boot_run();
        repeat (8) @(negedge clk);
        `CHK("oe_reset", 1'h1, sdo_oe_n)
        u_master.byte_x(8'hFF);
        `CHK("no_frame", 1'h0, frame_active)
        `CHK("no_byte", 1'h0, rx_valid)
        u_master.cs_n <= 1'h1;
        u_master.half();
    endtask

    // Full frame: n bytes in, the loaded byte echoed out after the first
    task automatic frame_rw(input logic m3, input int n, input logic [7:0] t);
        tx_data <= t;
        u_master.mode3 = m3;
        u_master.sel();
        `CHK("frame_active", 1'h1, frame_active)
        `CHK("standby_sel", 1'h0, standby)
        for (int i = 0; i < n; i++)
        begin
            u_master.byte_x(8'hA5 ^ 8'(i));
            if (i == 0)
                `CHK("oe_first", 1'h1, sdo_oe_n)
            else
                `CHK("sdo_byte", t, u_master.got)
        end
        u_master.desel();
        `CHK("oe_desel", 1'h1, sdo_oe_n)
        `CHK("tx_ready_desel", 1'h0, tx_ready)
        `CHK("overrun", n > 2, rx_overrun)
        for (int i = 0; i < 2; i++)
            pop(8'hA5 ^ 8'(i), 8'(i));
        `CHK("rx_empty", 1'h0, rx_valid)
    endtask

    // Pause in the middle of an output byte, then resume
    task automatic pause_run();
        logic [7:0] v;
        v = 8'h5A;
        u_master.mode3 = 1'h0;
        u_master.sel();
        u_master.byte_x(8'h96);
        for (int i = 7; i > 3; i--)
            u_master.bit_x(v[i]);
        `CHK("oe_live", 1'h0, sdo_oe_n)
        u_master.pause_on();
        `CHK("oe_pause", 1'h1, sdo_oe_n)
        `CHK("still_sel", 1'h1, frame_active)
        u_master.pause_off();
        for (int i = 3; i >= 0; i--)
            u_master.bit_x(v[i]);
        `CHK("sdo_resume", tx_data, u_master.got)
        u_master.desel();
        pop(8'h96, 8'h00);
        pop(8'h5A, 8'h01);
    endtask

    // Deselect while paused ends the frame and drops the partial byte
    task automatic abort_run();
        int a0;
        a0 = aborts;
        u_master.sel();
        u_master.byte_x(8'h3C);
        repeat (3) u_master.bit_x(1'h1);
        u_master.pause_on();
        u_master.cs_n <= 1'h1;
        u_master.half();
        u_master.hold_n <= 1'h1;
        u_master.half();
        `CHK("abort", a0 + 1, aborts)
        `CHK("frame_end", 1'h0, frame_active)
        pop(8'h3C, 8'h00);
        `CHK("partial_drop", 1'h0, rx_valid)
    endtask

    task automatic prot_set(input logic [1:0] v, output logic rf);
        prot_wr_value <= v;
        prot_wr_valid <= 1'h1;
        @(negedge clk) rf = prot_wr_refused;
        prot_wr_valid <= 1'h0;
        @(negedge clk);
    endtask

    task automatic query(input logic id, input logic [15:0] a, input logic e);
        chk_req <= '{addr: a, id_page: id};
        chk_valid <= 1'h1;
        @(negedge clk) chk_valid <= 1'h0;
        `CHK("chk_done", 1'h1, chk_done)
        `CHK("chk_permit", e, chk_permit)
        @(negedge clk);
    endtask

    // Every protect code against the region edges, then the freeze
    task automatic prot_run();
        logic rf;
        for (int p = 0; p < 4; p++)
        begin
            prot_set(2'(p), rf);
            `CHK("field", 2'(p), protect_field)
            `CHK("refused", 1'h0, rf)
            foreach (addrs[k])
                query(1'h0, addrs[k], !(p == 3 || (p == 2 && addrs[k] >= 16'h8000)
                    || (p == 1 && addrs[k] >= 16'hC000)));
        end
        u_master.wp_n <= 1'h0;
        repeat (6) @(negedge clk);
        prot_set(2'h0, rf);
        `CHK("frozen_ref", 1'h1, rf)
        `CHK("frozen", 2'h3, protect_field)
        u_master.wp_n <= 1'h1;
        query(1'h1, 16'h007F, 1'h1);
        query(1'h1, 16'h0080, 1'h0);
        id_lock_req <= 1'h1;
        @(negedge clk) id_lock_req <= 1'h0;
        `CHK("locked", 1'h1, id_locked)
        query(1'h1, 16'h0000, 1'h0);
    endtask

    // Standby only when deselected and no write runs
    task automatic stby_run();
        write_in_progress_flag <= 1'h1;
        repeat (2) @(negedge clk);
        `CHK("standby_wip", 1'h0, standby)
        write_in_progress_flag <= 1'h0;
        repeat (2) @(negedge clk);
        `CHK("standby_idle", 1'h1, standby)
    endtask

    initial
    begin
        repeat (2) @(negedge clk);
        rstn <= 1'h1;
        boot_run();
        frame_rw(1'h0, 3, 8'hC3);
        frame_rw(1'h1, 2, 8'h5B);
        pause_run();
        abort_run();
        prot_run();
        stby_run();
        give_verdict();
    end

    // Whole run needs well under 30 us
    initial
    begin
        #200us;
        mismatches++;
        give_verdict();
    end
endmodule // tb
